/* testbench/t1_frame_align_slip_control_asserts.sv */
`timescale 1ns/10ps
module t1_align_checker (
  // Clock and reset
  input wire logic                     sys_clk_i,
  input wire logic                     reset_n_i,
  // Bus
  input wire logic                     hsel_i,
  input wire logic [31:0]              haddr_i,
  input wire logic [1:0]               htrans_i,
  input wire logic                     hwrite_i,
  input wire logic [31:0]              hrdata_o,
  input wire logic                     hreadyout_o,
  input wire logic                     hresp_o,
  // Aligner and stream
  input wire logic                     fbit_valid_i,
  input wire logic                     fbit_err_i,
  input wire logic                     search_done_i,
  input wire logic [3:0]               cand_count_i,
  input wire logic                     bit_strobe_i,
  input wire logic                     ds_data_o,
  input wire logic                     inframe_o,
  input wire logic                     oof_o,
  input wire t1_align_pkg::frame_fmt_t frame_format_o,
  input wire logic [1:0]               dl_mode_o,
  input wire logic                     mimic_algo_o,
  input wire logic                     irq_out_n_o
);
  import t1_align_pkg::*;
  logic taken;
  assign taken = hsel_i && htrans_i[1];
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  bus_okay_a: assert property (hreadyout_o && !hresp_o && hrdata_o[31:8] == 24'h0)
    else $error("bus answer not okay");
  unmapped_rd_a: assert property (taken && !hwrite_i && haddr_i[11:2] == 10'h3F
    |=> hrdata_o == 32'h0) else $error("unmapped read not zero");
  oof_level_a: assert property (oof_o == !inframe_o)
    else $error("out of frame level wrong");
  mimic_refuse_a: assert property (search_done_i && !inframe_o
    && cand_count_i > 4'h1 && !mimic_algo_o |=> !inframe_o)
    else $error("frame declared with mimics");
  find_only_a: assert property (!inframe_o && !search_done_i |=> !inframe_o)
    else $error("in frame without search");
  good_bit_a: assert property (inframe_o && fbit_valid_i && !fbit_err_i
    && !search_done_i |=> inframe_o) else $error("frame lost on good bit");
  dl_esf_a: assert property (dl_mode_o != 2'h0 |-> frame_format_o == FMT_ESF)
    else $error("data link mode outside EXTENDED_SUPERFRAME_SELECT");
  ds_hold_a: assert property (!$past(bit_strobe_i) && !$past(bit_strobe_i, 2)
    |-> $stable(ds_data_o)) else $error("stream bit moved without strobe");
  irq_release_a: assert property ($rose(irq_out_n_o)
    |-> $past(taken, 2) || $past(taken, 3)) else $error("irq released alone");
endmodule : t1_align_checker

bind t1_frame_align_slip_control t1_align_checker u_chk (.*);

/* testbench/t1_frame_align_slip_control_test.sv */
`timescale 1ns/10ps
module t1_frame_align_slip_control_test;
  import t1_align_pkg::*;
  localparam logic [4:0] P_SLIP = 5'h10;
  localparam logic [4:0] P_SF   = 5'h08;
  localparam logic [4:0] P_SYNC = 5'h04;
  localparam logic [4:0] P_CRC  = 5'h02;
  localparam logic [4:0] P_FIND = 5'h01;
  logic        sys_clk_i, reset_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [1:0]  htrans_i, cand_idx_i, dl_mode_o;
  logic [2:0]  hsize_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic        fbit_valid_i, fbit_err_i, ft_err_i, crc_bit_valid_i;
  logic        crc_bit_i, slip_full_i, bit_strobe_i, chan_start_i;
  logic        rx_data_i, ds_data_o, inframe_o, irq_out_n_o;
  logic        slip_i, sf_start_i, sync_err_i, crc_sf_end_i, search_done_i;
  logic [3:0]  cand_count_i;
  logic [8:0]  align_pos_i;
  logic [5:0]  crc_rx_i;
  logic [4:0]  ev;
  logic [7:0]  v;
  frame_fmt_t  frame_format_o, ef;
  int          bad_count, samples_checked, cycles;
  logic [7:0]  codes [2] = '{8'hA5, 8'h3C};
  assign {slip_i, sf_start_i, sync_err_i, crc_sf_end_i, search_done_i} = ev;

  logic mimic_algo;
  logic [2:0]  lay;
  t1_frame_align_slip_control uut (.*, .hready_i(hreadyout_o), .oof_o(),
    .mimic_algo_o(mimic_algo), .best_cand_o(), .test_speedup_o(lay[2]),
    .ingress_layout_o(lay[1]), .egress_layout_o(lay[0]));
  t1_stream_partner far_end (.sys_clk_i, .reset_n_i,
    .bit_strobe_o(bit_strobe_i), .chan_start_o(chan_start_i),
    .rx_data_o(rx_data_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task lvl(input logic g, e);
    chk({31'h0, g}, {31'h0, e});
  endtask : lvl
  task wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wt
  task xfer(input logic [9:0] i, input logic w, input logic [7:0] d);
    @(posedge sys_clk_i);
    {hsel_i, htrans_i, hwrite_i} <= {1'b1, 2'h2, w};
    haddr_i <= {20'h0, i, 2'h0};
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    {hsel_i, htrans_i} <= 3'h0;
    hwdata_i <= {24'h0, d};
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
  endtask : xfer
  task wr(input logic [9:0] i, input logic [7:0] d);
    xfer(i, 1'b1, d);
  endtask : wr
  task rd_chk(input logic [9:0] i, input logic [7:0] e);
    xfer(i, 1'b0, 8'h00);
    chk(hrdata_o, {24'h0, e});
  endtask : rd_chk
  task pulse(input logic [4:0] m);
    @(posedge sys_clk_i);
    ev <= m;
    align_pos_i <= align_pos_i + 9'h001;
    @(posedge sys_clk_i);
    ev <= 5'h00;
  endtask : pulse
  task fbit(input logic e);
    @(posedge sys_clk_i);
    {fbit_valid_i, fbit_err_i} <= {1'b1, e};
    @(posedge sys_clk_i);
    {fbit_valid_i, fbit_err_i} <= 2'h0;
  endtask : fbit
  task get_chan();
    do @(posedge sys_clk_i); while (!(chan_start_i && bit_strobe_i));
    for (int i = 0; i < 8; i++) begin
      if (i > 0) do @(posedge sys_clk_i); while (!bit_strobe_i);
      wt(2);
      v = {v[6:0], ds_data_o};
    end
  endtask : get_chan

  initial begin
    {reset_n_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
    {fbit_valid_i, fbit_err_i, ft_err_i, crc_bit_valid_i, crc_bit_i} = '0;
    {crc_rx_i, cand_idx_i, slip_full_i, ev, cand_count_i} = '0;
    {align_pos_i, cycles, bad_count, samples_checked} = '0;
    hsize_i = 3'h2;
    repeat (2) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rd_chk(REG_IDX_STORE_FMT, 8'h00);
    rd_chk(REG_IDX_SLIP, 8'h00);
    rd_chk(REG_IDX_TROUBLE, 8'hFF);
    rd_chk(REG_IDX_ALIGN_FMT, 8'h00);
    rd_chk(REG_IDX_ALIGN_IRQ, 8'h00);
    rd_chk(10'h03F, 8'h00);
    wr(REG_IDX_STORE_FMT, 8'h00);
    chk({29'h0, lay}, 32'h0);
    $display("test reset finished");
    for (int k = 0; k < 2; k++) begin
      wr(REG_IDX_TROUBLE, codes[k]);
      get_chan(); // Channel under the write may be torn
      get_chan();
      chk({24'h0, v}, {24'h0, codes[k]});
    end
    $display("test trouble code finished");
    wr(REG_IDX_SLIP, 8'h04);
    slip_full_i <= 1'b1;
    pulse(P_SLIP);
    wt(2);
    lvl(irq_out_n_o, 1'b0);
    rd_chk(REG_IDX_SLIP, 8'h07);
    wt(2);
    lvl(irq_out_n_o, 1'b1);
    wr(REG_IDX_SLIP, 8'h00);
    pulse(P_SLIP);
    slip_full_i <= 1'b0;
    pulse(P_SLIP);
    wt(2);
    lvl(irq_out_n_o, 1'b1);
    rd_chk(REG_IDX_SLIP, 8'h01);
    $display("test slip finished");
    wr(REG_IDX_ALIGN_IRQ, 8'h01);
    cand_count_i <= 4'h1;
    pulse(P_FIND);
    wt(2);
    lvl(irq_out_n_o, 1'b0);
    rd_chk(REG_IDX_ALIGN_STAT, 8'h05);
    wt(2);
    lvl(irq_out_n_o, 1'b1);
    for (int r = 0; r < 3; r++) begin
      wr(REG_IDX_ALIGN_FMT, {r[1:0], 6'h00});
      if (inframe_o !== 1'b1) pulse(P_FIND);
      fbit(1'b1);
      repeat (3 + r) fbit(1'b0);
      fbit(1'b1);
      wt(1);
      lvl(inframe_o, 1'b1);
      repeat (2 + r) fbit(1'b0);
      fbit(1'b1);
      wt(1);
      lvl(inframe_o, 1'b0);
    end
    wr(REG_IDX_ALIGN_FMT, 8'h04);
    pulse(P_FIND);
    pulse(P_SF);
    pulse(P_SYNC);
    repeat (3) fbit(1'b1);
    wt(1);
    lvl(inframe_o, 1'b1);
    fbit(1'b1);
    wt(1);
    lvl(inframe_o, 1'b0);
    rd_chk(REG_IDX_ALIGN_STAT, 8'hF4);
    rd_chk(REG_IDX_ALIGN_STAT, 8'h00);
    wt(2);
    lvl(irq_out_n_o, 1'b1);
    $display("test loss of frame finished");
    wr(REG_IDX_ALIGN_FMT, 8'h10);
    wr(REG_IDX_ALIGN_IRQ, 8'h02);
    cand_count_i <= 4'h2;
    pulse(P_FIND);
    pulse(P_CRC);
    wt(2);
    lvl(inframe_o, 1'b0);
    lvl(irq_out_n_o, 1'b0);
    rd_chk(REG_IDX_ALIGN_STAT, 8'h0A);
    cand_count_i <= 4'h0;
    wt(3);
    rd_chk(REG_IDX_ALIGN_STAT, 8'h08);
    wr(REG_IDX_ALIGN_IRQ, 8'h10);
    cand_count_i <= 4'h1;
    pulse(P_FIND);
    wt(1);
    rd_chk(REG_IDX_ALIGN_STAT, 8'h85);
    wt(2);
    lvl(irq_out_n_o, 1'b1);
    fbit(1'b1);
    wt(2);
    lvl(irq_out_n_o, 1'b0);
    rd_chk(REG_IDX_ALIGN_STAT, 8'h41);
    $display("test aligner events finished");
    for (int i = 0; i < 7; i++) begin
      wr(REG_IDX_ALIGN_FMT, {2'h0, i[0], i[2], i[1:0], 2'h0});
      wt(1);
      ef = i[2] ? FMT_ESF : (i[1:0] == 2'h0) ? FMT_SF
         : (i[1:0] == 2'h2) ? FMT_LC : FMT_DM;
      chk({27'h0, frame_format_o, dl_mode_o, mimic_algo},
          {27'h0, ef, i[2] ? i[1:0] : 2'h0, i[0]});
    end
    $display("test formats finished");
    end_of_test();
  end
endmodule : t1_frame_align_slip_control_test

/* testbench/t1_stream_partner.sv */
`timescale 1ns/10ps
module t1_stream_partner (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  // Channel stream
  output logic      bit_strobe_o,
  output logic      chan_start_o,
  output logic      rx_data_o
);
  logic [4:0] tick_reg;
  // Strobe every fourth cycle, in the last of the four cycles that each bit is held
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_reg     <= 5'h00;
      bit_strobe_o <= 1'b0;
      chan_start_o <= 1'b0;
      rx_data_o    <= 1'b0;
    end else begin
      tick_reg     <= tick_reg + 5'h01;
      bit_strobe_o <= (tick_reg[1:0] == 2'h3);
      chan_start_o <= (tick_reg == 5'h1F);
      rx_data_o    <= tick_reg[2] ^ tick_reg[4];
    end
  end
endmodule : t1_stream_partner

/* verilog/t1_align_pkg.sv */
package t1_align_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] REG_IDX_STORE_FMT  = 10'h01C;
  localparam logic [9:0] REG_IDX_SLIP       = 10'h01D;
  localparam logic [9:0] REG_IDX_TROUBLE    = 10'h01E;
  localparam logic [9:0] REG_IDX_ALIGN_FMT  = 10'h020;
  localparam logic [9:0] REG_IDX_ALIGN_IRQ  = 10'h021;
  localparam logic [9:0] REG_IDX_ALIGN_STAT = 10'h022;

  // Field positions
  localparam int STF_SPEEDUP  = 7;
  localparam int STF_INGRESS  = 1;
  localparam int STF_EGRESS   = 0;
  localparam int SLP_EN       = 2;
  localparam int SLP_DIR      = 1;
  localparam int SLP_FLAG     = 0;
  localparam int AFC_OOF_HI   = 7;
  localparam int AFC_OOF_LO   = 6;
  localparam int AFC_ALGO     = 5;
  localparam int AFC_ESF      = 4;
  localparam int AFC_FMS_HI   = 3;
  localparam int AFC_FMS_LO   = 2;
  localparam int AIE_SPEEDUP  = 6;
  localparam int AIE_EN_HI    = 5;
  localparam int AST_FLAG_LO  = 2;
  localparam int AST_MIMIC    = 1;
  localparam int AST_INFRAME  = 0;

  // Event flag order inside the six-bit vectors
  localparam int EV_COFA   = 5;
  localparam int EV_FER    = 4;
  localparam int EV_BEE    = 3;
  localparam int EV_SFE    = 2;
  localparam int EV_MIMIC  = 1;
  localparam int EV_INFR   = 0;

  // Reset values
  localparam logic [7:0] TROUBLE_RESET = 8'hFF;
  localparam logic [7:0] CFG_RESET     = 8'h00;

  // Loss-of-frame windows and thresholds
  localparam logic [3:0] OOF_WIN_4  = 4'h4;
  localparam logic [3:0] OOF_WIN_5  = 4'h5;
  localparam logic [3:0] OOF_WIN_6  = 4'h6;
  localparam logic [3:0] OOF_WIN_DM = 4'hC;
  localparam logic [3:0] OOF_THR_2  = 4'h2;
  localparam logic [3:0] OOF_THR_DM = 4'h4;
  localparam int         OOF_HIST   = 12;

  localparam logic [1:0] SEVERE_COUNT = 2'h2;
  localparam logic [5:0] CRC6_POLY    = 6'h03;
  localparam int         CAND_NUM     = 4;

  typedef enum logic [1:0] {
    FMT_SF  = 2'h0,
    FMT_ESF = 2'h1,
    FMT_DM  = 2'h3,
    FMT_LC  = 2'h2
  } frame_fmt_t;

endpackage : t1_align_pkg

/* verilog/t1_frame_align_slip_control.sv */
`timescale 1ns/10ps
// Contract
// [R1] Software keeps both layout selects at zero
// [R2] Software keeps test speedup bits at zero
// [R3] Slip interrupts only when slip enable set
// [R4] Slip flag sets on slip, read clears
// [R5] Slip direction: one full, zero empty
// [R6] Out of frame substitutes programmable trouble code
// [R7] Trouble code sent most significant bit first
// [R8] Code write mid-frame corrupts one channel only
// [R9] Loss of frame ratio per ratio select
// [R10] Data-mux format uses four of twelve
// [R11] Algorithm zero: no frame with mimics
// [R12] Algorithm one: pick best CRC-6 candidate
// [R13] Extended superframe bit selects EXTENDED_SUPERFRAME_SELECT framing
// [R14] Mode pair selects SF, data-mux, loop-carrier
// [R15] Under EXTENDED_SUPERFRAME_SELECT mode pair sets data link
// [R16] Interrupt on new alignment position
// [R17] Interrupt on each framing bit error
// [R18] Interrupt on format specific bit error
// [R19] Interrupt on two errors per superframe
// [R20] Mimic flag; interrupt on both edges
// [R21] Interrupt on in-frame entry and exit
// [R22] Reset clears all aligner interrupt enables
// [R23] Aligner event flags clear on read
// [R24] Pending enabled interrupt drives output low
// [R25] Output held while enabled flag stays set
module t1_frame_align_slip_control (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_n_i,
  // AHB-Lite slave
  input  wire logic                    hsel_i,
  input  wire logic [31:0]             haddr_i,
  input  wire logic [1:0]              htrans_i,
  input  wire logic                    hwrite_i,
  input  wire logic [2:0]              hsize_i,
  input  wire logic                    hready_i,
  input  wire logic [31:0]             hwdata_i,
  output logic      [31:0]             hrdata_o,
  output logic                         hreadyout_o,
  output logic                         hresp_o,
  // Framing bit and candidate results
  input  wire logic                    fbit_valid_i,
  input  wire logic                    fbit_err_i,
  input  wire logic                    sync_err_i,
  input  wire logic                    ft_err_i,
  input  wire logic                    sf_start_i,
  input  wire logic                    search_done_i,
  input  wire logic [3:0]              cand_count_i,
  input  wire logic [8:0]              align_pos_i,
  // CRC-6 check stream
  input  wire logic                    crc_bit_valid_i,
  input  wire logic                    crc_bit_i,
  input  wire logic                    crc_sf_end_i,
  input  wire logic [5:0]              crc_rx_i,
  input  wire logic [1:0]              cand_idx_i,
  // Elastic store slips
  input  wire logic                    slip_i,
  input  wire logic                    slip_full_i,
  // Channel data stream
  input  wire logic                    bit_strobe_i,
  input  wire logic                    chan_start_i,
  input  wire logic                    rx_data_i,
  output logic                         ds_data_o,
  // Aligner state and configuration
  output logic                         inframe_o,
  output logic                         oof_o,
  output t1_align_pkg::frame_fmt_t     frame_format_o,
  output logic [1:0]                   dl_mode_o,
  output logic                         mimic_algo_o,
  output logic [1:0]                   best_cand_o,
  output logic                         test_speedup_o,
  output logic                         ingress_layout_o,
  output logic                         egress_layout_o,
  // Interrupt
  output logic                         irq_out_n_o
);
  import t1_align_pkg::*;

  function automatic frame_fmt_t decode_fmt(input logic [7:0] cfg);
    if (cfg[AFC_ESF]) begin
      decode_fmt = FMT_ESF;                                   // [R13]
    end else if (cfg[AFC_FMS_LO]) begin
      decode_fmt = FMT_DM;                                    // [R14]
    end else if (cfg[AFC_FMS_HI]) begin
      decode_fmt = FMT_LC;                                    // [R14]
    end else begin
      decode_fmt = FMT_SF;                                    // [R14]
    end
  endfunction : decode_fmt

  function automatic logic [3:0] count_low(input logic [11:0] h,
                                           input logic [3:0]  n);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < OOF_HIST; i++) begin
      if (h[i] && (i < int'(n))) begin
        c = c + 4'h1;
      end
    end
    count_low = c;
  endfunction : count_low

  logic [7:0]  store_fmt_reg;
  logic [7:0]  trouble_reg;
  logic [7:0]  align_fmt_reg;
  logic [7:0]  align_irq_reg;
  logic        slip_en_reg;
  logic        slip_flag_reg;
  logic        slip_dir_reg;
  logic [5:0]  ev_flag_reg;
  logic        inframe_reg;
  logic        mimic_reg;
  logic [8:0]  last_pos_reg;
  logic        pos_known_reg;
  logic [11:0] hist_reg;
  logic [1:0]  sf_err_reg;
  logic [5:0]  crc_reg;
  logic [2:0]  score_reg [CAND_NUM];
  logic [1:0]  best_reg;
  logic [7:0]  shadow_reg;
  logic [2:0]  bit_idx_reg;
  logic        ds_data_reg;
  logic        irq_n_reg;
  logic        wr_pend_reg;
  logic [9:0]  wr_idx_reg;
  logic [31:0] rdata_reg;

  frame_fmt_t  fmt;
  logic        take;
  logic        rd_take;
  logic [9:0]  ad_idx;
  logic        wr_go;
  logic [7:0]  wdata;
  logic        rd_slip;
  logic        rd_stat;
  logic [3:0]  oof_win;
  logic [3:0]  oof_thr;
  logic [11:0] hist_next;
  logic        oof_hit;
  logic        declare;
  logic        crc_bad;
  logic        bee_ev;
  logic        fer_ev;
  logic        sync_ev;
  logic        sfe_ev;
  logic        cofa_ev;
  logic        mimic_now;
  logic [5:0]  ev_set;
  logic [1:0]  best_next;
  logic [5:0]  crc_next;

  // Bus decode; zero wait states, so read data is sampled at address phase
  assign take    = hsel_i && hready_i && htrans_i[1];
  assign rd_take = take && !hwrite_i;
  assign ad_idx  = haddr_i[11:2];
  assign wr_go   = wr_pend_reg;
  assign wdata   = hwdata_i[7:0];
  assign rd_slip = rd_take && (ad_idx == REG_IDX_SLIP);
  assign rd_stat = rd_take && (ad_idx == REG_IDX_ALIGN_STAT);

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_reg;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 10'h000;
    end else begin
      wr_pend_reg <= take && hwrite_i;
      wr_idx_reg  <= ad_idx;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      store_fmt_reg <= CFG_RESET;
      trouble_reg   <= TROUBLE_RESET;                         // [R6]
      align_fmt_reg <= CFG_RESET;
      align_irq_reg <= CFG_RESET;                             // [R22]
      slip_en_reg   <= 1'b0;
    end else if (wr_go) begin
      if (wr_idx_reg == REG_IDX_STORE_FMT) begin
        store_fmt_reg <= wdata & 8'h83;
      end else if (wr_idx_reg == REG_IDX_SLIP) begin
        slip_en_reg <= wdata[SLP_EN];
      end else if (wr_idx_reg == REG_IDX_TROUBLE) begin
        trouble_reg <= wdata;
      end else if (wr_idx_reg == REG_IDX_ALIGN_FMT) begin
        align_fmt_reg <= wdata & 8'hFC;
      end else if (wr_idx_reg == REG_IDX_ALIGN_IRQ) begin
        align_irq_reg <= wdata & 8'h7F;
      end
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      if (ad_idx == REG_IDX_STORE_FMT) begin
        rdata_reg <= {24'h00_0000, store_fmt_reg};
      end else if (ad_idx == REG_IDX_SLIP) begin
        rdata_reg <= {29'h0000_0000, slip_en_reg, slip_dir_reg,
                      slip_flag_reg};
      end else if (ad_idx == REG_IDX_TROUBLE) begin
        rdata_reg <= {24'h00_0000, trouble_reg};
      end else if (ad_idx == REG_IDX_ALIGN_FMT) begin
        rdata_reg <= {24'h00_0000, align_fmt_reg};
      end else if (ad_idx == REG_IDX_ALIGN_IRQ) begin
        rdata_reg <= {24'h00_0000, align_irq_reg};
      end else if (ad_idx == REG_IDX_ALIGN_STAT) begin
        rdata_reg <= {24'h00_0000, ev_flag_reg, mimic_reg, inframe_reg};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  // Slip status; a slip in the read cycle survives the clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slip_flag_reg <= 1'b0;
      slip_dir_reg  <= 1'b0;
    end else begin
      if (slip_i) begin
        slip_flag_reg <= 1'b1;                                // [R4]
        slip_dir_reg  <= slip_full_i;                         // [R5]
      end else if (rd_slip) begin
        slip_flag_reg <= 1'b0;                                // [R4]
      end
    end
  end

  // Configuration decode
  assign fmt            = decode_fmt(align_fmt_reg);
  assign frame_format_o = fmt;
  assign dl_mode_o      = (fmt == FMT_ESF) ?
                          align_fmt_reg[AFC_FMS_HI:AFC_FMS_LO] : 2'h0; // [R15]
  assign mimic_algo_o   = align_fmt_reg[AFC_ALGO];
  // Production test and layout bits are passed out as written
  assign test_speedup_o   = store_fmt_reg[STF_SPEEDUP] |
                            align_irq_reg[AIE_SPEEDUP];       // [R2]
  assign ingress_layout_o = store_fmt_reg[STF_INGRESS];       // [R1]
  assign egress_layout_o  = store_fmt_reg[STF_EGRESS];        // [R1]

  // Loss-of-frame window over recent framing bits
  always_comb begin
    if (fmt == FMT_DM) begin
      oof_win = OOF_WIN_DM;                                   // [R10]
      oof_thr = OOF_THR_DM;                                   // [R10]
    end else begin
      oof_thr = OOF_THR_2;                                    // [R9]
      case (align_fmt_reg[AFC_OOF_HI:AFC_OOF_LO])
        2'h0:    oof_win = OOF_WIN_4;                         // [R9]
        2'h1:    oof_win = OOF_WIN_5;                         // [R9]
        2'h2:    oof_win = OOF_WIN_6;                         // [R9]
        default: oof_win = OOF_WIN_6;
      endcase
    end
  end

  assign hist_next = {hist_reg[10:0], fbit_err_i};
  assign oof_hit   = inframe_reg && fbit_valid_i &&
                     (count_low(hist_next, oof_win) >= oof_thr);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hist_reg <= 12'h000;
    end else if (!inframe_reg) begin
      hist_reg <= 12'h000;
    end else if (fbit_valid_i) begin
      hist_reg <= hist_next;
    end
  end

  // CRC-6 per candidate, x^6 + x + 1
  always_comb begin
    crc_next = {crc_reg[4:0], 1'b0};
    if (crc_reg[5] ^ crc_bit_i) begin
      crc_next = crc_next ^ CRC6_POLY;                        // [R12]
    end
  end

  assign crc_bad = crc_sf_end_i && (crc_reg != crc_rx_i);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      crc_reg <= 6'h00;
    end else if (crc_sf_end_i) begin
      crc_reg <= 6'h00;
    end else if (crc_bit_valid_i) begin
      crc_reg <= crc_next;                                    // [R12]
    end
  end

  always_comb begin
    best_next = 2'h0;
    for (int i = 1; i < CAND_NUM; i++) begin
      if (score_reg[i] > score_reg[best_next]) begin
        best_next = 2'(i);                                    // [R12]
      end
    end
  end

  // Scores restart once a search is resolved
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < CAND_NUM; i++) begin
        score_reg[i] <= 3'h0;
      end
      best_reg <= 2'h0;
    end else if (search_done_i) begin
      for (int i = 0; i < CAND_NUM; i++) begin
        score_reg[i] <= 3'h0;
      end
      best_reg <= best_next;
    end else if (crc_sf_end_i && !crc_bad && !inframe_reg &&
                 (score_reg[cand_idx_i] != 3'h7)) begin
      score_reg[cand_idx_i] <= score_reg[cand_idx_i] + 3'h1;  // [R12]
    end
  end

  assign best_cand_o = best_reg;

  // In-frame declaration
  assign mimic_now = !inframe_reg && (cand_count_i > 4'h1);   // [R20]
  always_comb begin
    declare = 1'b0;
    if (search_done_i && !inframe_reg) begin
      if ((fmt == FMT_ESF) && align_fmt_reg[AFC_ALGO]) begin
        declare = (cand_count_i != 4'h0);                     // [R12]
      end else begin
        declare = (cand_count_i == 4'h1);                     // [R11]
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      inframe_reg   <= 1'b0;
      mimic_reg     <= 1'b0;
      last_pos_reg  <= 9'h000;
      pos_known_reg <= 1'b0;
    end else begin
      mimic_reg <= mimic_now;                                 // [R20]
      if (declare) begin
        inframe_reg   <= 1'b1;
        last_pos_reg  <= align_pos_i;
        pos_known_reg <= 1'b1;
      end else if (oof_hit) begin
        inframe_reg <= 1'b0;                                  // [R9]
      end
    end
  end

  assign inframe_o = inframe_reg;
  assign oof_o     = !inframe_reg;

  // Error events
  assign fer_ev  = inframe_reg && fbit_valid_i && fbit_err_i;
  assign sync_ev = inframe_reg && (fmt == FMT_DM) && sync_err_i;
  assign cofa_ev = declare && pos_known_reg &&
                   (align_pos_i != last_pos_reg);             // [R16]
  always_comb begin
    case (fmt)
      FMT_ESF: bee_ev = inframe_reg && crc_bad;               // [R18]
      FMT_LC:  bee_ev = inframe_reg && ft_err_i;              // [R18]
      FMT_DM:  bee_ev = fer_ev || sync_ev;                    // [R18]
      default: bee_ev = fer_ev;                               // [R18]
    endcase
  end

  // Severe count saturates at two so it fires once per superframe
  assign sfe_ev = (sf_err_reg == 2'h1) && (fer_ev || sync_ev);
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sf_err_reg <= 2'h0;
    end else if (sf_start_i) begin
      sf_err_reg <= 2'h0;
    end else if ((fer_ev || sync_ev) && (sf_err_reg != SEVERE_COUNT)) begin
      sf_err_reg <= sf_err_reg + 2'h1;                        // [R19]
    end
  end

  always_comb begin
    ev_set           = 6'h00;
    ev_set[EV_COFA]  = cofa_ev;                               // [R16]
    ev_set[EV_FER]   = fer_ev;                                // [R17]
    ev_set[EV_BEE]   = bee_ev;                                // [R18]
    ev_set[EV_SFE]   = sfe_ev;                                // [R19]
    ev_set[EV_MIMIC] = mimic_now != mimic_reg;                // [R20]
    ev_set[EV_INFR]  = declare || oof_hit;                    // [R21]
  end

  // Set wins over the read clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ev_flag_reg <= 6'h00;
    end else if (rd_stat) begin
      ev_flag_reg <= ev_set;                                  // [R23]
    end else begin
      ev_flag_reg <= ev_flag_reg | ev_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= !((slip_en_reg && slip_flag_reg) ||         // [R3]
                     (|(ev_flag_reg &
                        align_irq_reg[AIE_EN_HI:0])));        // [R25]
    end
  end

  assign irq_out_n_o = irq_n_reg;                             // [R24]

  // Trouble code substitution; code is snapped per channel
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shadow_reg  <= TROUBLE_RESET;
      bit_idx_reg <= 3'h7;
      ds_data_reg <= 1'b1;
    end else begin
      if (chan_start_i) begin
        shadow_reg <= trouble_reg;                            // [R8]
      end
      if (bit_strobe_i) begin
        if (chan_start_i) begin
          ds_data_reg <= inframe_reg ? rx_data_i :
                         trouble_reg[7];                      // [R7]
          bit_idx_reg <= 3'h6;
        end else begin
          ds_data_reg <= inframe_reg ? rx_data_i :
                         shadow_reg[bit_idx_reg];             // [R6]
          bit_idx_reg <= bit_idx_reg - 3'h1;                  // [R7]
        end
      end else if (chan_start_i) begin
        bit_idx_reg <= 3'h7;
      end
    end
  end

  assign ds_data_o = ds_data_reg;

endmodule : t1_frame_align_slip_control
